// ==== verilog/cfw_params.svh ====
// Purpose: constants for the channel option and wake-frame filter block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets, field positions, reset values and counts
`ifndef CFW_PARAMS_SVH
`define CFW_PARAMS_SVH
`define CFW_ADDR_CTRL 12'h000
`define CFW_ADDR_TDC 12'h004
`define CFW_ADDR_STAT 12'h008
`define CFW_ECC_LSB 0
`define CFW_FMODE_LSB 4
`define CFW_TDCE_BIT 8
`define CFW_TDCSEL_BIT 9
`define CFW_ESIOPT_BIT 10
`define CFW_EFE_BIT 11
`define CFW_WMODE_LSB 16
`define CFW_WRET_LSB 18
`define CFW_KEEPAFL_BIT 20
`define CFW_STS_LSB 0
`define CFW_ERRCNT_LSB 8
`define CFW_TDCM_LSB 16
`define CFW_CTRL_RST 32'h0000_0000
`define CFW_TDC_RST 7'h00
`define CFW_ERRCNT_MAX 8'hFF
`define CFW_TDC_MAX 7'h7F
`define CFW_EF_MIN_TQ 2'h2
`endif

// ==== verilog/cfw_pkg.sv ====
// Purpose: types for the channel option and wake-frame filter block
// Assumes: used with cfw_params.svh
// Notes: state codes equal the status field codes
package cfw_pkg;
  // wake filter states, gray along acc -> id -> wake
  typedef enum logic [1:0] {
    CFW_ST_ACC = 2'h0,
    CFW_ST_ID = 2'h1,
    CFW_ST_WAKE = 2'h3,
    CFW_ST_PAY = 2'h2
  } cfw_wstate_t;
  typedef enum logic [1:0] {
    CFW_FM_MIX = 2'h0,
    CFW_FM_FDONLY = 2'h1,
    CFW_FM_CLONLY = 2'h2
  } cfw_fmode_t;
  typedef enum logic [2:0] {
    CFW_EC_ALL = 3'h0,
    CFW_EC_TX = 3'h1,
    CFW_EC_RX = 3'h2,
    CFW_EC_FD_ALL = 3'h3,
    CFW_EC_FD_TX = 3'h4,
    CFW_EC_FD_RX = 3'h5
  } cfw_econd_t;
  // bus error event from the protocol engine
  typedef struct packed {
    logic err;
    logic in_tx;
    logic in_fd_data;
  } cfw_err_ev_t;
  // end-of-frame filter results, per wake rule
  typedef struct packed {
    logic done;
    logic [1:0] wake_id_hit;
    logic [1:0] wake_pay_ok;
    logic afl_hit;
  } cfw_rx_ev_t;
  // buffering decision
  typedef struct packed {
    logic valid;
    logic store;
    logic by_wake;
    logic rule;
  } cfw_store_t;
endpackage

// ==== verilog/cfw_channel.sv ====
// Purpose: CAN-FD channel options and wake-frame filter decision
// Assumes: all inputs synchronous to core_clk, APB slave with zero waits
// Notes: protocol engine and comparators sit outside this block
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cfw_params.svh"
module cfw_channel (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chan_reset_mode,
  input wire cfw_pkg::cfw_err_ev_t err_ev,
  input wire logic node_err_passive,
  input wire logic tx_req_fd,
  input wire logic tx_msg_esi,
  output logic tx_fdf_q,
  output logic tx_esi_q,
  input wire logic rx_fmt_valid,
  input wire logic rx_fdf,
  output logic err_frame_req_q,
  output logic fmt_err_q,
  input wire logic tdc_window,
  input wire logic tx_bit,
  input wire logic rx_bit,
  output logic [7:0] ssp_pos_q,
  input wire logic bus_idle,
  input wire logic tq_tick,
  output logic rx_filt_q,
  input wire cfw_pkg::cfw_rx_ev_t rx_ev,
  output cfw_pkg::cfw_store_t store_q
);
  import cfw_pkg::*;

  logic [31:0] ctrl_q;
  logic [6:0] tdc_off_q;
  cfw_wstate_t state_q;
  logic [1:0] status_q;
  logic keep_afl_q;
  logic [7:0] err_cnt_q;
  logic [6:0] tdc_meas_q;
  logic [6:0] tdc_run_q;
  logic tdc_busy_q;
  logic tx_bit_q;
  logic rx_bit_q;
  logic ef_act_q;
  logic [1:0] dom_cnt_q;
  logic wr_en;
  logic rd_en;
  logic wr_ctrl;
  logic addr_ok;
  cfw_econd_t econd;
  cfw_fmode_t fmode;
  cfw_wstate_t wr_mode;
  cfw_wstate_t ret_mode;
  logic err_hit;
  logic auto_exit;
  logic [1:0] sel_hit;
  logic sel_rule;
  logic sel_any;
  logic sel_pay;

  // first wake rule whose ID filter matches, lowest number first
  // no hit at all reads as rule 0, so an acceptance-list store reports a clean rule field
  function automatic logic first_rule(input logic [1:0] hit);
    first_rule = !hit[0] && hit[1];
  endfunction

  // error condition decode
  function automatic logic cond_match(input cfw_econd_t c, input cfw_err_ev_t e);
    case (c)
      CFW_EC_ALL: cond_match = 1'b1;
      CFW_EC_TX: cond_match = e.in_tx;
      CFW_EC_RX: cond_match = !e.in_tx;
      CFW_EC_FD_ALL: cond_match = e.in_fd_data;
      CFW_EC_FD_TX: cond_match = e.in_fd_data && e.in_tx;
      CFW_EC_FD_RX: cond_match = e.in_fd_data && !e.in_tx;
      default: cond_match = 1'b0;
    endcase
  endfunction

  // apb decode, no wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign wr_ctrl = wr_en && (paddr == `CFW_ADDR_CTRL);
  always_comb begin
    if (paddr == `CFW_ADDR_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == `CFW_ADDR_TDC) begin
      addr_ok = 1'b1;
    end else if (paddr == `CFW_ADDR_STAT) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end
  assign pslverr = psel && penable && !addr_ok;

  // control field views
  assign econd = cfw_econd_t'(ctrl_q[`CFW_ECC_LSB +: 3]);
  assign fmode = cfw_fmode_t'(ctrl_q[`CFW_FMODE_LSB +: 2]);
  assign wr_mode = cfw_wstate_t'(pwdata[`CFW_WMODE_LSB +: 2]);
  assign ret_mode = cfw_wstate_t'(ctrl_q[`CFW_WRET_LSB +: 2]);

  // read data register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `CFW_ADDR_CTRL) begin
        prdata <= ctrl_q;
      end else if (paddr == `CFW_ADDR_TDC) begin
        prdata <= {25'h0000000, tdc_off_q};
      end else if (paddr == `CFW_ADDR_STAT) begin
        prdata <= {9'h000, tdc_meas_q, err_cnt_q, 6'h00, status_q};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // control and offset registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= `CFW_CTRL_RST;
      tdc_off_q <= `CFW_TDC_RST;
    end else if (wr_en) begin
      if (paddr == `CFW_ADDR_CTRL) begin
        ctrl_q <= pwdata;
      end else if (paddr == `CFW_ADDR_TDC) begin
        tdc_off_q <= pwdata[6:0];
      end
    end
  end

  // error occurrence counter, saturating
  assign err_hit = err_ev.err && cond_match(econd, err_ev);
  always_ff @(posedge core_clk) begin
    if (sys_rst || chan_reset_mode) begin
      err_cnt_q <= 8'h00;
    end else if (err_hit && err_cnt_q != `CFW_ERRCNT_MAX) begin
      err_cnt_q <= err_cnt_q + 8'h01;
    end
  end

  // transmit format and esi
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_fdf_q <= 1'b0;
      tx_esi_q <= 1'b0;
    end else begin
      case (fmode)
        CFW_FM_FDONLY: tx_fdf_q <= 1'b1;
        CFW_FM_CLONLY: tx_fdf_q <= 1'b0;
        default: tx_fdf_q <= tx_req_fd;
      endcase
      if (ctrl_q[`CFW_ESIOPT_BIT] && !node_err_passive) begin
        tx_esi_q <= tx_msg_esi;
      end else begin
        tx_esi_q <= node_err_passive;
      end
    end
  end

  // received format check
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      err_frame_req_q <= 1'b0;
      fmt_err_q <= 1'b0;
    end else begin
      err_frame_req_q <= rx_fmt_valid && !rx_fdf && fmode == CFW_FM_FDONLY;
      fmt_err_q <= rx_fmt_valid && rx_fdf && fmode == CFW_FM_CLONLY;
    end
  end

  // loop delay: tx falling edge to bus falling edge, in clocks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_bit_q <= 1'b1;
      rx_bit_q <= 1'b1;
      tdc_busy_q <= 1'b0;
      tdc_run_q <= 7'h00;
      tdc_meas_q <= 7'h00;
    end else begin
      tx_bit_q <= tx_bit;
      rx_bit_q <= rx_bit;
      if (!ctrl_q[`CFW_TDCE_BIT] || !tdc_window) begin
        tdc_busy_q <= 1'b0;
      end else if (!tdc_busy_q && tx_bit_q && !tx_bit) begin
        tdc_busy_q <= 1'b1;
        tdc_run_q <= 7'h00;
      end else if (tdc_busy_q && rx_bit_q && !rx_bit) begin
        tdc_busy_q <= 1'b0;
        tdc_meas_q <= tdc_run_q;
      end else if (tdc_busy_q && tdc_run_q != `CFW_TDC_MAX) begin
        tdc_run_q <= tdc_run_q + 7'h01;
      end
    end
  end

  // secondary sample point
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ssp_pos_q <= 8'h00;
    end else if (ctrl_q[`CFW_TDCSEL_BIT]) begin
      ssp_pos_q <= {1'b0, tdc_off_q};
    end else begin
      ssp_pos_q <= {1'b0, tdc_meas_q} + {1'b0, tdc_off_q};
    end
  end

  // receive edge filter, armed at idle, disarmed once an edge passes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ef_act_q <= 1'b0;
      dom_cnt_q <= 2'h0;
      rx_filt_q <= 1'b1;
    end else if (!ctrl_q[`CFW_EFE_BIT]) begin
      ef_act_q <= 1'b0;
      dom_cnt_q <= 2'h0;
      rx_filt_q <= rx_bit;
    end else if (ef_act_q) begin
      if (rx_bit) begin
        dom_cnt_q <= 2'h0; // short pulse ignored
        rx_filt_q <= 1'b1;
      end else if (tq_tick && dom_cnt_q + 2'h1 >= `CFW_EF_MIN_TQ) begin
        rx_filt_q <= 1'b0;
        ef_act_q <= 1'b0;
        dom_cnt_q <= 2'h0;
      end else if (tq_tick) begin
        dom_cnt_q <= dom_cnt_q + 2'h1;
      end
    end else begin
      rx_filt_q <= rx_bit;
      ef_act_q <= bus_idle;
    end
  end

  // wake rule selection
  assign sel_hit = rx_ev.wake_id_hit;
  assign sel_any = |sel_hit;
  assign sel_rule = first_rule(sel_hit);
  assign sel_pay = rx_ev.wake_pay_ok[sel_rule];
  assign auto_exit = state_q == CFW_ST_WAKE && rx_ev.done && sel_any && sel_pay;

  // filter state; a mode write that changes the state wins over an automatic exit
  always_ff @(posedge core_clk) begin
    if (sys_rst || chan_reset_mode) begin
      state_q <= CFW_ST_ACC;
      keep_afl_q <= 1'b1;
    end else if (wr_ctrl && wr_mode != state_q) begin
      state_q <= wr_mode;
      keep_afl_q <= pwdata[`CFW_KEEPAFL_BIT] || wr_mode == CFW_ST_ACC;
    end else if (auto_exit) begin
      state_q <= ret_mode;
      keep_afl_q <= ctrl_q[`CFW_KEEPAFL_BIT] || ret_mode == CFW_ST_ACC;
    end
  end

  // status follows state one cycle later
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_q <= 2'h0;
    end else begin
      status_q <= state_q;
    end
  end

  // buffering decision at end of frame, format ignored
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      store_q <= '0;
    end else begin
      store_q.valid <= rx_ev.done;
      store_q.rule <= sel_rule;
      store_q.by_wake <= 1'b0;
      store_q.store <= 1'b0;
      if (rx_ev.done) begin
        case (state_q)
          CFW_ST_ID: begin
            if (sel_any) begin
              store_q.store <= 1'b1;
              store_q.by_wake <= 1'b1;
            end else begin
              store_q.store <= rx_ev.afl_hit && keep_afl_q;
            end
          end
          CFW_ST_PAY: begin
            if (sel_any) begin
              store_q.store <= sel_pay;
              store_q.by_wake <= 1'b1;
            end else begin
              store_q.store <= rx_ev.afl_hit && keep_afl_q;
            end
          end
          CFW_ST_WAKE: begin
            store_q.store <= sel_any && sel_pay;
            store_q.by_wake <= sel_any;
          end
          default: store_q.store <= rx_ev.afl_hit;
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_err_count;
    err_hit && !chan_reset_mode && err_cnt_q != 8'hFF |=> err_cnt_q == $past(err_cnt_q) + 8'h01;
  endproperty
  a_err_count: assert property (p_err_count) else $error("error counter missed");

  property p_err_ignore;
    err_ev.err && !err_hit && !chan_reset_mode |=> $stable(err_cnt_q);
  endproperty
  a_err_ignore: assert property (p_err_ignore) else $error("off-condition count");

  property p_auto_exit;
    auto_exit && !wr_ctrl && !chan_reset_mode |=> state_q == $past(ret_mode)
      ##1 status_q == $past(ret_mode, 2);
  endproperty
  a_auto_exit: assert property (p_auto_exit) else $error("wake exit wrong");

  property p_fd_only;
    fmode == CFW_FM_FDONLY |=> tx_fdf_q;
  endproperty
  a_fd_only: assert property (p_fd_only) else $error("classic sent in fd-only");

  property p_cl_only;
    fmode == CFW_FM_CLONLY |=> !tx_fdf_q;
  endproperty
  a_cl_only: assert property (p_cl_only) else $error("fd sent in classic-only");

  property p_err_frame;
    rx_fmt_valid && !rx_fdf && fmode == CFW_FM_FDONLY |=> err_frame_req_q;
  endproperty
  a_err_frame: assert property (p_err_frame) else $error("no error frame");

  property p_esi;
    !node_err_passive && ctrl_q[`CFW_ESIOPT_BIT] |=> tx_esi_q == $past(tx_msg_esi);
  endproperty
  a_esi: assert property (p_esi) else $error("esi option two wrong");

  property p_esi_own;
    node_err_passive |=> tx_esi_q;
  endproperty
  a_esi_own: assert property (p_esi_own) else $error("passive esi not 1");

  property p_chan_reset;
    chan_reset_mode |=> state_q == CFW_ST_ACC ##1 status_q == 2'h0;
  endproperty
  a_chan_reset: assert property (p_chan_reset) else $error("not normal after reset");

  property p_pay_fail;
    rx_ev.done && state_q == CFW_ST_PAY && sel_any && !sel_pay |=> store_q.valid && !store_q.store;
  endproperty
  a_pay_fail: assert property (p_pay_fail) else $error("failed payload stored");

  c_auto_exit: cover property (auto_exit);
  c_fd_err: cover property (err_frame_req_q);
  c_wake_store: cover property (store_q.store && store_q.by_wake);
endmodule

// ==== test/cfw_bus_model.sv ====
// Purpose: far side of the bus, seen through a transceiver
// Assumes: wired-and bus, 0 is dominant
// Notes: dom stands for another node driving dominant
`timescale 1ns/1ps
module cfw_bus_model #(
  parameter int DLY = 5
) (
  input wire logic core_clk,
  input wire logic tx_bit,
  input wire logic dom,
  output logic rx_bit
);
  logic [DLY-1:0] pipe_q;
  // transceiver loop delay line
  always_ff @(posedge core_clk) begin
    pipe_q <= {pipe_q[DLY-2:0], tx_bit};
  end
  // other node can pull the bus dominant at any time
  assign rx_bit = pipe_q[DLY-1] & ~dom;
endmodule

// ==== test/cfw_channel_test.sv ====
// Purpose: self-checking bench for cfw_channel
// Assumes: zero-wait APB slave, tq tick every 4 clocks
// Notes: the bus model echoes tx with a fixed loop delay
`timescale 1ns/1ps
`include "cfw_params.svh"
module cfw_channel_test;
  import cfw_pkg::*;
  localparam int DLY = 5;
  logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, low, b, chan_reset_mode = 1'b0, node_err_passive = 1'b0;
  logic tx_req_fd = 1'b0, tx_msg_esi = 1'b0, tx_fdf_q, tx_esi_q, rx_fmt_valid = 1'b0;
  logic rx_fdf = 1'b0, err_frame_req_q, fmt_err_q, tdc_window = 1'b0, tx_bit = 1'b1;
  logic rx_bit, dom = 1'b0, bus_idle = 1'b0, tq_tick = 1'b0, rx_filt_q;
  logic [7:0] ssp_pos_q;
  logic [1:0] tq_cnt = 2'h0;
  logic [9:0] ev_pat = 10'h3D8;
  logic [31:0] cnt_tab [6] = '{32'h5, 32'h3, 32'h2, 32'h3, 32'h2, 32'h1};
  cfw_err_ev_t err_ev = '0;
  cfw_rx_ev_t rx_ev = '0;
  cfw_store_t store_q;
  int num_errors = 0, compares = 0, m;

  cfw_channel uut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chan_reset_mode, .err_ev, .node_err_passive, .tx_req_fd, .tx_msg_esi,
    .tx_fdf_q, .tx_esi_q, .rx_fmt_valid, .rx_fdf, .err_frame_req_q, .fmt_err_q, .tdc_window,
    .tx_bit, .rx_bit, .ssp_pos_q, .bus_idle, .tq_tick, .rx_filt_q, .rx_ev, .store_q);
  cfw_bus_model #(.DLY(DLY)) bus (.core_clk, .tx_bit, .dom, .rx_bit);

  // clock and a tq tick every fourth cycle
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tq_cnt <= tq_cnt + 2'h1;
    tq_tick <= (tq_cnt == 2'h3);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic sts(input int e);
    apb(1'b0, `CFW_ADDR_STAT, 32'h0);
    check({30'h0, rd[1:0]}, 32'(e));
  endtask

  // leave through acceptance-only so the switch is always a change
  task automatic wmode(input int md, input int r, input int kp);
    apb(1'b1, `CFW_ADDR_CTRL, 32'h0);
    apb(1'b1, `CFW_ADDR_CTRL, (32'(md) << 16) | (32'(r) << 18) | (32'(kp) << 20));
    sts(md);
  endtask

  // one end-of-frame result; rule fields compared only when stored
  task automatic frame(input logic [1:0] id, input logic [1:0] pay, input logic acceptance_list_filter,
                       input logic [3:0] exp);
    rx_ev <= {1'b1, id, pay, acceptance_list_filter};
    @(posedge core_clk);
    rx_ev <= '0;
    #1;
    check({28'h0, store_q.valid, store_q.store, store_q.store ? {store_q.by_wake, store_q.rule}
      : 2'b00}, {28'h0, exp});
    @(posedge core_clk);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, `CFW_ADDR_CTRL, 32'h0);
    check(rd, `CFW_CTRL_RST);
    sts(0);
    apb(1'b0, 12'h00C, 32'h0);
    check({er, rd[30:0]}, 32'h8000_0000);
    // acceptance list only with wake hits ignored, then ID-filter and payload wake modes
    frame(2'b00, 2'b00, 1'b1, 4'hC);
    frame(2'b01, 2'b01, 1'b0, 4'h8);
    for (int kp = 0; kp < 2; kp++) begin
      wmode(1, 0, kp);
      frame(2'b00, 2'b00, 1'b1, kp ? 4'hC : 4'h8);
    end
    frame(2'b10, 2'b00, 1'b1, 4'hF);
    wmode(2, 0, 1);
    frame(2'b11, 2'b10, 1'b1, 4'h8);
    frame(2'b11, 2'b01, 1'b0, 4'hE);
    frame(2'b00, 2'b11, 1'b1, 4'hC);
    // wake-only mode and every return state
    for (int r = 0; r < 4; r++) begin
      wmode(3, r, 1);
      frame(2'b00, 2'b00, 1'b1, 4'h8);
      frame(2'b10, 2'b01, 1'b0, 4'h8);
      frame(2'b10, 2'b10, 1'b0, 4'hF);
      sts(r);
    end
    // error counter under each condition
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, `CFW_ADDR_CTRL, 32'(c));
      chan_reset_mode <= 1'b1;
      @(posedge core_clk);
      chan_reset_mode <= 1'b0;
      for (int k = 4; k >= 0; k--) begin
        err_ev <= {1'b1, ev_pat[2*k+1], ev_pat[2*k]};
        @(posedge core_clk);
        err_ev <= '0;
        @(posedge core_clk);
      end
      apb(1'b0, `CFW_ADDR_STAT, 32'h0);
      check({24'h0, rd[15:8]}, cnt_tab[c]);
    end
    // frame format modes, send and receive
    for (int i = 0; i < 6; i++) begin
      m = i / 2;
      b = i[0];
      apb(1'b1, `CFW_ADDR_CTRL, 32'(m) << `CFW_FMODE_LSB);
      tx_req_fd <= b;
      rx_fdf <= b;
      rx_fmt_valid <= 1'b1;
      @(posedge core_clk);
      rx_fmt_valid <= 1'b0;
      #1;
      check({31'h0, tx_fdf_q}, {31'h0, m == 1 || (m == 0 && b)});
      check({31'h0, err_frame_req_q}, {31'h0, m == 1 && !b});
      check({31'h0, fmt_err_q}, {31'h0, m == 2 && b});
      @(posedge core_clk);
    end
    // error state indicator, both options
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `CFW_ADDR_CTRL, 32'(i / 4) << `CFW_ESIOPT_BIT);
      node_err_passive <= i[1];
      tx_msg_esi <= i[0];
      @(posedge core_clk);
      #1;
      check({31'h0, tx_esi_q}, {31'h0, (i > 3 && !i[1]) ? i[0] : i[1]});
      @(posedge core_clk);
    end
    // loop delay measurement and secondary sample point
    apb(1'b1, `CFW_ADDR_TDC, 32'h0000_0010);
    apb(1'b1, `CFW_ADDR_CTRL, 32'h1 << `CFW_TDCE_BIT);
    tdc_window <= 1'b1;
    tx_bit <= 1'b0;
    repeat (12) @(posedge core_clk);
    tx_bit <= 1'b1;
    tdc_window <= 1'b0;
    repeat (8) @(posedge core_clk);
    apb(1'b0, `CFW_ADDR_STAT, 32'h0);
    #1;
    check({31'h0, rd[22:16] inside {[DLY - 1:DLY + 2]}}, 32'h1);
    check({24'h0, ssp_pos_q}, {25'h0, rd[22:16]} + 32'h10);
    @(posedge core_clk);
    apb(1'b1, `CFW_ADDR_CTRL, 32'h3 << `CFW_TDCE_BIT);
    repeat (2) @(posedge core_clk);
    #1;
    check({24'h0, ssp_pos_q}, 32'h10);
    @(posedge core_clk);
    // edge filter: short dominant ignored, long one passes
    apb(1'b1, `CFW_ADDR_CTRL, 32'h1 << `CFW_EFE_BIT);
    bus_idle <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus_idle <= 1'b0;
    low = 1'b0;
    for (int k = 0; k < 22; k++) begin
      dom <= (k < 2 || k > 9);
      @(negedge core_clk);
      if (k < 10)
        low = low | (rx_filt_q !== 1'b1);
      @(posedge core_clk);
    end
    check({31'h0, low}, 32'h0);
    check({31'h0, rx_filt_q}, 32'h0);
    dom <= 1'b0;
    test_done();
  end
endmodule
